/* File: core/urx_pkg.sv */
package urx_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  // ctrl_status_a fields
  localparam int ST_RXC_POS = 7;
  localparam int ST_FE_POS  = 4;
  localparam int ST_DOR_POS = 3;
  localparam int ST_PE_POS  = 2;
  localparam int ST_U2X_POS = 1;
  // ctrl_status_b fields
  localparam int CB_RXCIE_POS = 7;
  localparam int CB_RXEN_POS  = 4;
  localparam int CB_CSZ2_POS  = 2;
  localparam int CB_RXB8_POS  = 1;
  localparam int CB_TXB8_POS  = 0;
  // ctrl_status_c fields
  localparam int CC_SYNC_POS = 6;
  localparam int CC_PEN_POS  = 5;
  localparam int CC_PODD_POS = 4;
  localparam int CC_SBS_POS  = 3;
  localparam int CC_CSZ_LSB  = 1;

  localparam logic [11:0] BAUD_RST  = 12'h000;
  localparam logic [2:0]  CSZ_RST   = 3'h3;
  localparam logic [2:0]  CSZ_NINE  = 3'h7;
  localparam logic [3:0]  BITS_BASE = 4'h5;
  localparam logic [3:0]  BITS_NINE = 4'h9;
  localparam logic [4:0]  SPB_NORMAL = 5'h10;
  localparam logic [4:0]  SPB_DOUBLE = 5'h08;
  localparam logic [4:0]  CTR_NORMAL = 5'h08;
  localparam logic [4:0]  CTR_DOUBLE = 5'h04;
  localparam logic [1:0]  FIFO_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } urx_state_e;

  typedef struct packed {
    logic       rx_en;
    logic       rxcie;
    logic       u2x;
    logic       sync;
    logic       par_en;
    logic       par_odd;
    logic       sbs;
    logic       txb8;
    logic [2:0] csz;
  } urx_cfg_s;

  typedef struct packed {
    logic       ninth;
    logic       fe;
    logic       dor;
    logic       pe;
    logic [7:0] data;
  } urx_entry_s;
endpackage : urx_pkg

/* File: core/urx_receiver.sv */
`timescale 1ns/1ps
// Overview of operation
// - Setting rx_enable starts the receiver and hands it the data pin.
// - Synchronous mode times bits from sync_clock_pin, not the baud counter.
// - Reception starts on a valid start bit, shifts bits to stop bit.
// - Only the first stop bit matters, whatever stop_bits_select says.
// - After the first stop bit the frame moves into the receive buffer.
// - Data reads zero the bits above the configured character size.
// - Nine-bit frames show the ninth bit as rx_ninth_bit in control B.
// - Ninth bit and error flags live per FIFO entry; data read advances.
// - rx_complete_flag is one exactly while the buffer holds unread data.
// - Interrupt follows rx_complete_flag when enabled and globally allowed.
// - Reading data removes the entry; handler must read to stop interrupt.
// - Status writes never alter frame, overrun or parity error flags.
// - The error flags never raise an interrupt themselves.
// - frame_error_flag shows a zero first stop bit of the head frame.
// - Full buffer, waiting frame and new start bit flag an overrun.
// - overrun_flag clears when a frame is moved into the buffer.
// - Parity checker compares data parity to parity bit, stores result.
// - parity_error_flag only when checked and failed; zero when disabled.
// - Clearing rx_enable stops at once, discards and flushes everything.
// - Async line is sampled 16x per bit, 8x with double_speed_bit.
// - Start bit kept only if majority of samples 8-10 (4-6) are low.
// - Each async bit is a two-of-three vote over its three centre samples.
module urx_receiver (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_PIN,
  input  wire logic        SYNC_CLK_PIN,
  input  wire logic        GLOBAL_IRQ_EN,
  output logic             RX_IRQ,
  output logic             RX_PIN_OWNED
);

  function automatic logic maj3(input logic a, input logic b,
                                input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == urx_pkg::CSZ_NINE) begin
      data_bits = urx_pkg::BITS_NINE;
    end else begin
      data_bits = urx_pkg::BITS_BASE + {2'h0, csz[1:0]};
    end
  endfunction : data_bits

  urx_pkg::urx_cfg_s   cfg;
  urx_pkg::urx_state_e state;
  urx_pkg::urx_entry_s fifo [2];
  urx_pkg::urx_entry_s hold, head;
  logic [11:0] baud_div, baud_cnt;
  logic [4:0]  spb, ctr, scnt;
  logic [3:0]  bit_idx, nbits;
  logic [1:0]  votes, count;
  logic [8:0]  shreg;
  logic [31:0] next_rdata;
  logic        tick, samp, start_det, bit_done, bit_val, seen_high;
  logic        rx_meta, rx_sync, xck_meta, xck_sync, xck_prev, xck_rise;
  logic        par_acc, pe_cap, pending, ovr_flag, full, push, pop;
  logic        wr_ptr, rd_ptr, apb_acc, apb_first, next_err;

  // Pin and external clock cross into MCLK through two flops each
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rx_meta  <= 1'b1;
      rx_sync  <= 1'b1;
      xck_meta <= 1'b0;
      xck_sync <= 1'b0;
      xck_prev <= 1'b0;
    end else begin
      rx_meta  <= RX_PIN;
      rx_sync  <= rx_meta;
      xck_meta <= SYNC_CLK_PIN;
      xck_sync <= xck_meta;
      xck_prev <= xck_sync;
    end
  end
  assign xck_rise = xck_sync & ~xck_prev;
  // Baud divider: one sample enable every baud_div+1 clocks
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      baud_cnt <= urx_pkg::BAUD_RST;
    end else if (baud_cnt == 12'h000) begin
      baud_cnt <= baud_div;
    end else begin
      baud_cnt <= baud_cnt - 12'h001;
    end
  end

  assign tick  = (baud_cnt == 12'h000);
  assign samp  = cfg.sync ? xck_rise : tick;
  assign spb   = cfg.u2x ? urx_pkg::SPB_DOUBLE : urx_pkg::SPB_NORMAL;
  assign ctr   = cfg.u2x ? urx_pkg::CTR_DOUBLE : urx_pkg::CTR_NORMAL;
  assign nbits = data_bits(cfg.csz);
  assign full  = (count == urx_pkg::FIFO_DEPTH);

  // A start needs a high sample before the low one, so a stuck-low
  // line after enable is not taken as a stream of start bits.
  assign start_det = cfg.rx_en && state == urx_pkg::ST_IDLE && samp
                     && seen_high && !rx_sync;

  // Async bits end on the third centre sample; sync bits on each rising edge
  assign bit_done = cfg.sync ? (xck_rise && state != urx_pkg::ST_IDLE)
                  : (tick && state != urx_pkg::ST_IDLE
                     && scnt == ctr + 5'h02);
  assign bit_val  = cfg.sync ? rx_sync
                  : maj3(votes[1], votes[0], rx_sync);

  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      seen_high <= 1'b0;
    end else if (start_det) begin
      seen_high <= 1'b0;
    end else if (samp) begin
      seen_high <= rx_sync;
    end
  end

  // Sample counter, 1..spb within each bit, and centre vote history
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      scnt  <= 5'h00;
      votes <= 2'h0;
    end else if (start_det) begin
      scnt  <= 5'h02;
    end else if (tick && state != urx_pkg::ST_IDLE) begin
      scnt  <= (scnt == spb) ? 5'h01 : scnt + 5'h01;
      if (scnt >= ctr && scnt <= ctr + 5'h01) begin
        votes <= {votes[0], rx_sync};
      end
    end
  end

  // Frame state machine
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      state   <= urx_pkg::ST_IDLE;
      bit_idx <= 4'h0;
      shreg   <= 9'h000;
      par_acc <= 1'b0;
      pe_cap  <= 1'b0;
    end else if (start_det) begin
      bit_idx <= 4'h0;
      par_acc <= 1'b0;
      pe_cap  <= 1'b0;
      shreg   <= 9'h000;
      state   <= cfg.sync ? urx_pkg::ST_DATA : urx_pkg::ST_START;
    end else if (bit_done) begin
      unique case (state)
        urx_pkg::ST_START: begin
          state <= bit_val ? urx_pkg::ST_IDLE : urx_pkg::ST_DATA;
        end
        urx_pkg::ST_DATA: begin
          shreg[bit_idx] <= bit_val;
          par_acc        <= par_acc ^ bit_val;
          bit_idx        <= bit_idx + 4'h1;
          if (bit_idx == nbits - 4'h1) begin
            state <= cfg.par_en ? urx_pkg::ST_PAR : urx_pkg::ST_STOP;
          end
        end
        urx_pkg::ST_PAR: begin
          pe_cap <= par_acc ^ bit_val ^ cfg.par_odd;
          state  <= urx_pkg::ST_STOP;
        end
        urx_pkg::ST_STOP: begin
          state <= urx_pkg::ST_IDLE;
        end
        default: begin
          state <= urx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Finished frame waits here until the FIFO has room
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      hold    <= '0;
      pending <= 1'b0;
    end else if (bit_done && state == urx_pkg::ST_STOP) begin
      hold.data  <= shreg[7:0];
      hold.ninth <= shreg[8];
      hold.fe    <= !bit_val;
      hold.pe    <= pe_cap & cfg.par_en;
      hold.dor   <= 1'b0;
      pending    <= 1'b1;
    end else if (push) begin
      pending <= 1'b0;
    end
  end

  // Set wins: overrun only arises while full, when no push can happen
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      ovr_flag <= 1'b0;
    end else if (start_det && pending && full) begin
      ovr_flag <= 1'b1;
    end else if (push) begin
      ovr_flag <= 1'b0;
    end
  end

  assign push = pending && !full;
  assign pop  = apb_acc && !PWRITE && PADDR == urx_pkg::ADDR_DATA
                && count != 2'h0;

  // Two-entry receive FIFO with per-entry status
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !cfg.rx_en) begin
      count  <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else begin
      if (push) begin
        fifo[wr_ptr]     <= hold;
        fifo[wr_ptr].dor <= ovr_flag;
        wr_ptr           <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  assign head = (count != 2'h0) ? fifo[rd_ptr] : '0;
  // APB slave, one wait state: data is prepared in the first access
  // cycle and the transfer completes on the second.
  assign apb_first = PSEL && PENABLE && !PREADY;
  assign apb_acc   = PSEL && PENABLE && PREADY;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (PADDR)
      urx_pkg::ADDR_STATUS: begin
        next_rdata[urx_pkg::ST_RXC_POS] = (count != 2'h0);
        next_rdata[urx_pkg::ST_FE_POS]  = head.fe;
        next_rdata[urx_pkg::ST_DOR_POS] = head.dor;
        next_rdata[urx_pkg::ST_PE_POS]  = head.pe;
        next_rdata[urx_pkg::ST_U2X_POS] = cfg.u2x;
      end
      urx_pkg::ADDR_CTRL_B: begin
        next_rdata[urx_pkg::CB_RXCIE_POS] = cfg.rxcie;
        next_rdata[urx_pkg::CB_RXEN_POS]  = cfg.rx_en;
        next_rdata[urx_pkg::CB_CSZ2_POS]  = cfg.csz[2];
        next_rdata[urx_pkg::CB_RXB8_POS]  =
          (cfg.csz == urx_pkg::CSZ_NINE) & head.ninth;
        next_rdata[urx_pkg::CB_TXB8_POS]  = cfg.txb8;
      end
      urx_pkg::ADDR_CTRL_C: begin
        next_rdata[urx_pkg::CC_SYNC_POS] = cfg.sync;
        next_rdata[urx_pkg::CC_PEN_POS]  = cfg.par_en;
        next_rdata[urx_pkg::CC_PODD_POS] = cfg.par_odd;
        next_rdata[urx_pkg::CC_SBS_POS]  = cfg.sbs;
        next_rdata[urx_pkg::CC_CSZ_LSB+:2] = cfg.csz[1:0];
      end
      urx_pkg::ADDR_DATA: begin
        for (int i = 0; i < 8; i++) begin
          next_rdata[i] = head.data[i] & (4'(i) < nbits);
        end
      end
      urx_pkg::ADDR_BAUD: begin
        next_rdata[11:0] = baud_div;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_first;
      PSLVERR <= apb_first && next_err;
      if (apb_first && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  // Software-written configuration; error flags have no write path
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cfg      <= '0;
      cfg.csz  <= urx_pkg::CSZ_RST;
      baud_div <= urx_pkg::BAUD_RST;
    end else if (apb_acc && PWRITE) begin
      unique case (PADDR)
        urx_pkg::ADDR_STATUS: begin
          cfg.u2x <= PWDATA[urx_pkg::ST_U2X_POS];
        end
        urx_pkg::ADDR_CTRL_B: begin
          cfg.rxcie  <= PWDATA[urx_pkg::CB_RXCIE_POS];
          cfg.rx_en  <= PWDATA[urx_pkg::CB_RXEN_POS];
          cfg.csz[2] <= PWDATA[urx_pkg::CB_CSZ2_POS];
          cfg.txb8   <= PWDATA[urx_pkg::CB_TXB8_POS];
        end
        urx_pkg::ADDR_CTRL_C: begin
          cfg.sync     <= PWDATA[urx_pkg::CC_SYNC_POS];
          cfg.par_en   <= PWDATA[urx_pkg::CC_PEN_POS];
          cfg.par_odd  <= PWDATA[urx_pkg::CC_PODD_POS];
          cfg.sbs      <= PWDATA[urx_pkg::CC_SBS_POS];
          cfg.csz[1:0] <= PWDATA[urx_pkg::CC_CSZ_LSB+:2];
        end
        urx_pkg::ADDR_BAUD: begin
          baud_div <= PWDATA[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Interrupt depends on the flag and its two enables, never on error bits
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      RX_IRQ <= 1'b0;
    end else begin
      RX_IRQ <= cfg.rxcie && GLOBAL_IRQ_EN && count != 2'h0;
    end
  end
  assign RX_PIN_OWNED = cfg.rx_en;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_stop_done;
    bit_done && state == urx_pkg::ST_STOP;
  endsequence
  sequence s_start_reject;
    bit_done && state == urx_pkg::ST_START && bit_val;
  endsequence

  AST_DISABLE_FLUSH: assert property (
    $fell(cfg.rx_en) |=> count == 2'h0 && state == urx_pkg::ST_IDLE
                         && !RX_PIN_OWNED)
    else $error("disable did not flush receiver");
  AST_FRAME_PUSH: assert property (
    s_stop_done ##1 (!full && cfg.rx_en) |-> push)
    else $error("completed frame not moved to buffer");
  AST_START_REJECT: assert property (
    s_start_reject |=> state == urx_pkg::ST_IDLE)
    else $error("noisy start bit not rejected");
  AST_OVR_SET: assert property (
    start_det && pending && full |=> ovr_flag)
    else $error("overrun not flagged");
  AST_OVR_CLEAR: assert property (
    push && !(start_det && pending && full) |=> !ovr_flag)
    else $error("overrun flag not cleared on transfer");
  AST_IRQ_FOLLOW: assert property (
    cfg.rxcie && GLOBAL_IRQ_EN && count != 2'h0 |=> RX_IRQ)
    else $error("receive interrupt missing");
  AST_NO_ERR_IRQ: assert property (
    RX_IRQ |-> $past(count) != 2'h0)
    else $error("interrupt without unread data");
  AST_PE_OFF: assert property (
    s_stop_done ##0 !cfg.par_en |=> !hold.pe)
    else $error("parity error with checking off");
  AST_READ_POP: assert property (
    pop && !push && cfg.rx_en |=> count == $past(count) - 2'h1)
    else $error("data read did not remove entry");
  AST_FLAGS_STABLE: assert property (
    apb_acc && PWRITE && PADDR == urx_pkg::ADDR_STATUS && !push
    && cfg.rx_en |=> $stable(head))
    else $error("status write changed error flags");
  AST_DATA_MASK: assert property (
    apb_first && !PWRITE && PADDR == urx_pkg::ADDR_DATA
    && cfg.csz == 3'h0 |=> PRDATA[7:5] == 3'h0)
    else $error("unused data bits not masked");

endmodule : urx_receiver

/* File: verif/urx_receiver_tb_top.sv */
`timescale 1ns/1ps
module urx_receiver_tb_top;
  localparam int BIT = 32;
  logic        mclk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, glb, rerr;
  logic        pready, pslverr, rx_pin, sck, irq, owned;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #12.5 mclk = ~mclk;
  urx_receiver urx_receiver_i (.MCLK(mclk), .SYS_RST(sys_rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_PIN(rx_pin), .SYNC_CLK_PIN(sck),
    .GLOBAL_IRQ_EN(glb), .RX_IRQ(irq), .RX_PIN_OWNED(owned));
  urx_tx_model urx_tx_model_i (.MCLK(mclk), .LINE(rx_pin), .SCK(sck));
  task automatic print_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdata);
  endtask : rd
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask : settle
  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      apb(1'b0, urx_pkg::ADDR_STATUS, 32'h0000_0000);
      n++;
    end while (rdata[urx_pkg::ST_RXC_POS] !== 1'b1 && n < 30);
    if (n >= 30) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_rx
  function automatic logic [11:0] mk(logic [8:0] d, int nd, logic pe,
                                     logic pb, logic stop);
    logic [11:0] v;
    v = 12'hFFF;
    v[0] = 1'b0;
    for (int i = 0; i < nd; i++) v[i+1] = d[i];
    if (pe) v[nd+1] = pb;
    v[nd+1+int'(pe)] = stop;
    return v;
  endfunction : mk
  task automatic rx(input logic [11:0] f, input int cpb, input logic sy,
                    input logic [31:0] st, input logic [31:0] d);
    urx_tx_model_i.send(f, cpb, sy);
    wait_rx();
    rd(urx_pkg::ADDR_STATUS, st, "status");
    rd(urx_pkg::ADDR_DATA, d, "data");
  endtask : rx
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    glb = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(urx_pkg::ADDR_STATUS, 32'h0, "status");
    rd(urx_pkg::ADDR_CTRL_B, 32'h0, "ctrl_b");
    rd(urx_pkg::ADDR_CTRL_C, 32'h6, "ctrl_c");
    rd(urx_pkg::ADDR_BAUD, 32'h0, "baud");
    rd(8'h14, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("owned", 32'h0, {31'h0, owned});
    wr(urx_pkg::ADDR_BAUD, 32'h1);
    wr(urx_pkg::ADDR_CTRL_C, 32'h0E);
    wr(urx_pkg::ADDR_CTRL_B, 32'h10);
    settle();
    chk("owned", 32'h1, {31'h0, owned});
    urx_tx_model_i.glitch(6);
    repeat (600) @(posedge mclk);
    rd(urx_pkg::ADDR_STATUS, 32'h0, "status");
    rx(mk(9'h0A5, 8, 0, 0, 1), BIT, 0, 32'h80, 32'hA5);
    rx(mk(9'h05A, 8, 0, 0, 0), BIT, 0, 32'h90, 32'h5A);
    urx_tx_model_i.send(mk(9'h0F5, 8, 0, 0, 1), BIT, 0);
    wait_rx();
    wr(urx_pkg::ADDR_CTRL_C, 32'h00);
    rd(urx_pkg::ADDR_DATA, 32'h15, "data");
    rx(mk(9'h1F5, 5, 0, 0, 1), BIT, 0, 32'h80, 32'h15);
    wr(urx_pkg::ADDR_CTRL_B, 32'h14);
    wr(urx_pkg::ADDR_CTRL_C, 32'h06);
    for (int k = 0; k < 2; k++) begin
      urx_tx_model_i.send(mk({k[0], 8'hA5}, 9, 0, 0, 1), BIT, 0);
      wait_rx();
      rd(urx_pkg::ADDR_CTRL_B, 32'h14 | (k << 1), "ninth");
      rd(urx_pkg::ADDR_DATA, 32'hA5, "data");
    end
    wr(urx_pkg::ADDR_CTRL_B, 32'h10);
    for (int k = 0; k < 4; k++) begin
      wr(urx_pkg::ADDR_CTRL_C, 32'h26 | (k[0] << 4));
      rx(mk(9'h03D, 8, 1, ^8'h3D ^ k[0] ^ k[1], 1), BIT, 0,
         32'h80 | (k[1] << 2), 32'h3D);
    end
    wr(urx_pkg::ADDR_CTRL_C, 32'h06);
    wr(urx_pkg::ADDR_STATUS, 32'h02);
    rx(mk(9'h03C, 8, 0, 0, 1), BIT / 2, 0, 32'h82, 32'h3C);
    wr(urx_pkg::ADDR_STATUS, 32'h00);
    wr(urx_pkg::ADDR_CTRL_C, 32'h46);
    rx(mk(9'h096, 8, 0, 0, 1), 6, 1, 32'h80, 32'h96);
    wr(urx_pkg::ADDR_CTRL_C, 32'h06);
    for (int k = 1; k < 5; k++)
      urx_tx_model_i.send(mk(9'(k * 8'h11), 8, 0, 0, 1), BIT, 0);
    rd(urx_pkg::ADDR_STATUS, 32'h80, "status");
    wr(urx_pkg::ADDR_STATUS, 32'h1C);
    rd(urx_pkg::ADDR_STATUS, 32'h80, "status");
    rd(urx_pkg::ADDR_DATA, 32'h11, "data");
    rd(urx_pkg::ADDR_STATUS, 32'h80, "status");
    rd(urx_pkg::ADDR_DATA, 32'h22, "data");
    rd(urx_pkg::ADDR_STATUS, 32'h88, "status");
    wr(urx_pkg::ADDR_STATUS, 32'h1C);
    rd(urx_pkg::ADDR_STATUS, 32'h88, "status");
    rd(urx_pkg::ADDR_DATA, 32'h44, "data");
    rd(urx_pkg::ADDR_STATUS, 32'h0, "status");
    rx(mk(9'h055, 8, 0, 0, 1), BIT, 0, 32'h80, 32'h55);
    glb <= 1'b1;
    urx_tx_model_i.send(mk(9'h066, 8, 0, 0, 1), BIT, 0);
    wr(urx_pkg::ADDR_CTRL_B, 32'h90);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge mclk) glb <= 1'b0;
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge mclk) glb <= 1'b1;
    rd(urx_pkg::ADDR_DATA, 32'h66, "data");
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    urx_tx_model_i.send(mk(9'h077, 8, 0, 0, 1), BIT, 0);
    urx_tx_model_i.send(mk(9'h088, 8, 0, 0, 1), BIT, 0);
    wr(urx_pkg::ADDR_CTRL_B, 32'h00);
    settle();
    chk("owned", 32'h0, {31'h0, owned});
    chk("irq", 32'h0, {31'h0, irq});
    rd(urx_pkg::ADDR_STATUS, 32'h0, "status");
    wr(urx_pkg::ADDR_CTRL_B, 32'h10);
    fork
      urx_tx_model_i.send(mk(9'h0FF, 8, 0, 0, 1), BIT, 0);
      begin
        repeat (100) @(posedge mclk);
        wr(urx_pkg::ADDR_CTRL_B, 32'h00);
        wr(urx_pkg::ADDR_CTRL_B, 32'h10);
      end
    join
    repeat (100) @(posedge mclk);
    rd(urx_pkg::ADDR_STATUS, 32'h0, "status");
    print_verdict();
  end
endmodule : urx_receiver_tb_top

/* File: verif/urx_tx_model.sv */
`timescale 1ns/1ps
module urx_tx_model (
  input  wire logic MCLK,
  output logic      LINE,
  output logic      SCK
);
  // Line driven idle high; sync clock stands still between frames
  initial begin
    LINE = 1'b1;
    SCK  = 1'b0;
  end
  // Bits go out LSB first; ones past the stop bit read as idle
  task automatic send(input logic [11:0] bits, input int cpb,
                      input logic sync);
    for (int i = 0; i < 12; i++) begin
      @(posedge MCLK);
      LINE <= bits[i];
      if (sync) begin
        repeat (cpb) @(posedge MCLK);
        SCK <= 1'b1;
        repeat (cpb) @(posedge MCLK);
        SCK <= 1'b0;
      end else begin
        repeat (cpb - 1) @(posedge MCLK);
      end
    end
    @(posedge MCLK);
    LINE <= 1'b1;
  endtask : send
  // Short low pulse that a real start bit must outlast
  task automatic glitch(input int n);
    @(posedge MCLK);
    LINE <= 1'b0;
    repeat (n) @(posedge MCLK);
    LINE <= 1'b1;
  endtask : glitch
endmodule : urx_tx_model
